// ==== design/efc_map.svh ====
// constants of the embedded dual clock fifo controller
`ifndef EFC_MAP_SVH
`define EFC_MAP_SVH

`define EFC_DATA_W    36
`define EFC_PTR_W     13
`define EFC_MEM_BITS  4608
`define EFC_ASPECT_W  3
`define EFC_DEPTH_MAX 13'h1000
`define EFC_PTR_RST   13'h0000
`define EFC_DATA_RST  36'h0_0000_0000
`define EFC_LAST_AS   3'h5

`endif

// ==== design/efc_pkg.sv ====
// types of the embedded dual clock fifo controller
`include "efc_map.svh"

package efc_pkg;

  typedef enum logic [`EFC_ASPECT_W-1:0] {
    EFC_AS_4KX1   = 3'h0,
    EFC_AS_2KX2   = 3'h1,
    EFC_AS_1KX4   = 3'h2,
    EFC_AS_512X9  = 3'h3,
    EFC_AS_256X18 = 3'h4,
    EFC_AS_128X36 = 3'h5
  } efc_aspect_e;

  typedef logic [`EFC_PTR_W-1:0] efc_ptr_t;

  typedef struct packed {
    efc_aspect_e aspect;
    efc_ptr_t    nearly_full_level;
    efc_ptr_t    nearly_empty_level;
  } efc_cfg_s;

endpackage

// ==== design/efc_sync.sv ====
// two flip-flop synchroniser for a level or a gray coded word
`timescale 1ns/1ps

module efc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds the second and nothing else
  always_ff @(posedge clk)
  begin
    meta_r <= d;
    q_r    <= meta_r;
  end

  assign q = q_r;

endmodule

// ==== design/efc_fifo_ctrl.sv ====
// dual clock fifo controller over one 4608 bit memory block
`timescale 1ns/1ps
`include "efc_map.svh"

// Function
// - outside reset, each write clock edge with write enable high and full low stores the input word.
// - outside reset, each read clock edge with read enable high and empty low presents the next word.
// - full lives in the write domain and blocks writes while set.
// - empty lives in the read domain and blocks reads while set.
// - both pointers cross domains only as gray code.
// - nearly full and nearly drained flags have programmable levels.
// - the organisation is selectable from 4k x 1 down to 128 x 36.
// - reset returns the fifo to empty with both pointers cleared.
// - writes use only the write clock and reads only the read clock.
// - the usable depth follows from the selected word width.
// - one write port, one read port, and flags from flip-flops only.
module efc_fifo_ctrl (
  input  wire logic                   wr_clk,
  input  wire logic                   rd_clk,
  input  wire logic                   resetn,
  input  wire efc_pkg::efc_cfg_s      cfg,
  input  wire logic [`EFC_DATA_W-1:0] write_word_in,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  output logic      [`EFC_DATA_W-1:0] read_word_out,
  output logic                        full,
  output logic                        nearly_filled_flag,
  output logic                        empty,
  output logic                        nearly_drained_flag
);

  localparam int DW = `EFC_DATA_W;
  localparam int PW = `EFC_PTR_W;
  localparam int CW = $bits(efc_pkg::efc_cfg_s);

  function automatic logic [5:0] width_of(efc_pkg::efc_aspect_e a);
    unique case (a)
      efc_pkg::EFC_AS_4KX1:   width_of = 6'h01;
      efc_pkg::EFC_AS_2KX2:   width_of = 6'h02;
      efc_pkg::EFC_AS_1KX4:   width_of = 6'h04;
      efc_pkg::EFC_AS_512X9:  width_of = 6'h09;
      efc_pkg::EFC_AS_256X18: width_of = 6'h12;
      efc_pkg::EFC_AS_128X36: width_of = 6'h24;
      default:                width_of = 6'h24;
    endcase
  endfunction

  // depth halves with each step of width; illegal codes act as 128 x 36
  function automatic efc_pkg::efc_ptr_t depth_of(efc_pkg::efc_aspect_e a);
    logic [2:0] s;
    s = (a > `EFC_LAST_AS) ? `EFC_LAST_AS : a;
    depth_of = `EFC_DEPTH_MAX >> s;
  endfunction

  function automatic efc_pkg::efc_ptr_t bin2gray(efc_pkg::efc_ptr_t b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic efc_pkg::efc_ptr_t gray2bin(efc_pkg::efc_ptr_t g);
    efc_pkg::efc_ptr_t b;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    gray2bin = b;
  endfunction

  // bit offset of a word slot in the shared memory
  function automatic efc_pkg::efc_ptr_t base_of(efc_pkg::efc_ptr_t p,
                                                efc_pkg::efc_ptr_t d,
                                                logic [5:0]        w);
    logic [18:0] prod;
    prod = (p & (d - 13'h0001)) * w;
    base_of = prod[PW-1:0];
  endfunction

  // ---------------- domain crossings ----------------
  logic                w_rst_n;
  logic                r_rst_n;
  efc_pkg::efc_cfg_s   wcfg;
  efc_pkg::efc_cfg_s   rcfg;
  efc_pkg::efc_ptr_t   wgray_r;
  efc_pkg::efc_ptr_t   rgray_r;
  efc_pkg::efc_ptr_t   rgray_w;
  efc_pkg::efc_ptr_t   wgray_rd;
  logic [CW-1:0]       wcfg_bits;
  logic [CW-1:0]       rcfg_bits;

  efc_sync #(.W(1)) u_wrst (.clk(wr_clk), .d(resetn), .q(w_rst_n));
  efc_sync #(.W(1)) u_rrst (.clk(rd_clk), .d(resetn), .q(r_rst_n));
  // configuration is expected to change only while reset is held
  efc_sync #(.W(CW)) u_wcfg (.clk(wr_clk), .d(cfg), .q(wcfg_bits));
  efc_sync #(.W(CW)) u_rcfg (.clk(rd_clk), .d(cfg), .q(rcfg_bits));
  // gray pointers change one bit per step, so a torn sample is
  // always either the old or the new pointer
  efc_sync #(.W(PW)) u_r2w (.clk(wr_clk), .d(rgray_r), .q(rgray_w));
  efc_sync #(.W(PW)) u_w2r (.clk(rd_clk), .d(wgray_r), .q(wgray_rd));

  assign wcfg = efc_pkg::efc_cfg_s'(wcfg_bits);
  assign rcfg = efc_pkg::efc_cfg_s'(rcfg_bits);

  logic mem_r [0:`EFC_MEM_BITS-1];

  // ---------------- write domain ----------------
  efc_pkg::efc_ptr_t wbin_r;
  efc_pkg::efc_ptr_t wbin_nxt;
  efc_pkg::efc_ptr_t wgray_nxt;
  efc_pkg::efc_ptr_t wdepth;
  efc_pkg::efc_ptr_t wmask;
  efc_pkg::efc_ptr_t wcount;
  efc_pkg::efc_ptr_t wbase;
  logic [5:0]        wwidth;
  logic              wr_take;
  logic              full_r;
  logic              full_nxt;
  logic              nearly_filled_flag_r;
  logic              nearly_filled_flag_nxt;

  always_comb
  begin
    wwidth  = width_of(wcfg.aspect);
    wdepth  = depth_of(wcfg.aspect);
    wmask   = (wdepth << 1) - 13'h0001;
    wr_take = wr_en & ~full_r;
    wbase   = base_of(wbin_r, wdepth, wwidth);
    wbin_nxt = wr_take ? ((wbin_r + 13'h0001) & wmask) : wbin_r;
    wcount   = (wbin_nxt - gray2bin(rgray_w)) & wmask;
    full_nxt  = (wcount == wdepth);
    nearly_filled_flag_nxt = (wcount >= wcfg.nearly_full_level);
    wgray_nxt = bin2gray(wbin_nxt);
    if (!w_rst_n)
    begin
      wbin_nxt  = `EFC_PTR_RST;
      wgray_nxt = `EFC_PTR_RST;
      full_nxt  = 1'b0;
      nearly_filled_flag_nxt = 1'b0;
    end
  end

  // flags are registered, so they never glitch
  always_ff @(posedge wr_clk)
  begin
    wbin_r  <= wbin_nxt;
    wgray_r <= wgray_nxt;
    full_r  <= full_nxt;
    nearly_filled_flag_r <= nearly_filled_flag_nxt;
  end

  always_ff @(posedge wr_clk)
  begin
    if (w_rst_n && wr_take)
    begin
      for (int b = 0; b < DW; b++)
        if (b < int'(wwidth))
          mem_r[int'(wbase) + b] <= write_word_in[b];
    end
  end

  assign full               = full_r;
  assign nearly_filled_flag = nearly_filled_flag_r;

  // ---------------- read domain ----------------
  efc_pkg::efc_ptr_t rbin_r;
  efc_pkg::efc_ptr_t rbin_nxt;
  efc_pkg::efc_ptr_t rgray_nxt;
  efc_pkg::efc_ptr_t rdepth;
  efc_pkg::efc_ptr_t rmask;
  efc_pkg::efc_ptr_t rcount;
  efc_pkg::efc_ptr_t rbase;
  logic [5:0]        rwidth;
  logic              rd_take;
  logic              empty_r;
  logic              empty_nxt;
  logic              nearly_drained_flag_r;
  logic              nearly_drained_flag_nxt;
  logic [DW-1:0]     rdata_r;
  logic [DW-1:0]     rdata_nxt;

  always_comb
  begin
    rwidth  = width_of(rcfg.aspect);
    rdepth  = depth_of(rcfg.aspect);
    rmask   = (rdepth << 1) - 13'h0001;
    rd_take = rd_en & ~empty_r;
    rbase   = base_of(rbin_r, rdepth, rwidth);
    rdata_nxt = rdata_r;
    if (rd_take)
    begin
      rdata_nxt = `EFC_DATA_RST;
      for (int b = 0; b < DW; b++)
        if (b < int'(rwidth))
          rdata_nxt[b] = mem_r[int'(rbase) + b];
    end
    rbin_nxt   = rd_take ? ((rbin_r + 13'h0001) & rmask) : rbin_r;
    rcount     = (gray2bin(wgray_rd) - rbin_nxt) & rmask;
    empty_nxt  = (rcount == `EFC_PTR_RST);
    nearly_drained_flag_nxt = (rcount <= rcfg.nearly_empty_level);
    rgray_nxt  = bin2gray(rbin_nxt);
    if (!r_rst_n)
    begin
      rbin_nxt   = `EFC_PTR_RST;
      rgray_nxt  = `EFC_PTR_RST;
      empty_nxt  = 1'b1;
      nearly_drained_flag_nxt = 1'b1;
      rdata_nxt  = `EFC_DATA_RST;
    end
  end

  always_ff @(posedge rd_clk)
  begin
    rbin_r   <= rbin_nxt;
    rgray_r  <= rgray_nxt;
    empty_r  <= empty_nxt;
    nearly_drained_flag_r <= nearly_drained_flag_nxt;
    rdata_r  <= rdata_nxt;
  end

  assign read_word_out       = rdata_r;
  assign empty               = empty_r;
  assign nearly_drained_flag = nearly_drained_flag_r;

  // ---------------- checks ----------------
  // flags are built from the crossed pointer as it stood one edge earlier,
  // so the checks hold that pointer back by the same edge
  efc_pkg::efc_ptr_t rgray_w_q;
  efc_pkg::efc_ptr_t wgray_rd_q;
  efc_pkg::efc_ptr_t wfill;
  efc_pkg::efc_ptr_t rfill;

  always_ff @(posedge wr_clk)
  begin
    rgray_w_q <= rgray_w;
  end

  always_ff @(posedge rd_clk)
  begin
    wgray_rd_q <= wgray_rd;
  end

  assign wfill = (wbin_r - gray2bin(rgray_w_q)) & wmask;
  assign rfill = (gray2bin(wgray_rd_q) - rbin_r) & rmask;

  a_full_blocks_write: assert property (
    @(posedge wr_clk) disable iff (!w_rst_n)
    full_r && wr_en |=> wbin_r == $past(wbin_r))
    else $error("write pointer moved while full");

  a_write_advances_ptr: assert property (
    @(posedge wr_clk) disable iff (!w_rst_n)
    wr_en && !full_r |=> wbin_r == ((($past(wbin_r) + 13'h0001)) & wmask))
    else $error("accepted write did not advance the pointer");

  a_fill_within_depth: assert property (
    @(posedge wr_clk) disable iff (!w_rst_n)
    w_rst_n |-> wfill <= wdepth && (full_r == (wfill == wdepth)))
    else $error("fill level exceeds depth or full disagrees");

  a_wgray_one_step: assert property (
    @(posedge wr_clk) disable iff (!w_rst_n)
    w_rst_n |-> $onehot0(wgray_r ^ $past(wgray_r)))
    else $error("write gray pointer changed in more than one bit");

  a_nearly_full_level: assert property (
    @(posedge wr_clk) disable iff (!w_rst_n)
    ##1 nearly_filled_flag_r == (wfill >= wcfg.nearly_full_level))
    else $error("nearly full flag disagrees with fill level");

  a_wreset_clears: assert property (
    @(posedge wr_clk) disable iff (!w_rst_n)
    $rose(w_rst_n) |-> wbin_r == `EFC_PTR_RST && !full_r)
    else $error("write side not cleared by reset");

  a_empty_blocks_read: assert property (
    @(posedge rd_clk) disable iff (!r_rst_n)
    empty_r && rd_en |=> rbin_r == $past(rbin_r) && $stable(rdata_r))
    else $error("read taken while empty");

  a_read_advances_ptr: assert property (
    @(posedge rd_clk) disable iff (!r_rst_n)
    rd_en && !empty_r |=> rbin_r == ((($past(rbin_r) + 13'h0001)) & rmask))
    else $error("accepted read did not advance the pointer");

  a_rgray_one_step: assert property (
    @(posedge rd_clk) disable iff (!r_rst_n)
    r_rst_n |-> $onehot0(rgray_r ^ $past(rgray_r)))
    else $error("read gray pointer changed in more than one bit");

  a_nearly_drained_lvl: assert property (
    @(posedge rd_clk) disable iff (!r_rst_n)
    ##1 (empty_r == (rfill == `EFC_PTR_RST)) &&
        (nearly_drained_flag_r == (rfill <= rcfg.nearly_empty_level)))
    else $error("read side flags disagree with fill level");

  a_rreset_empties: assert property (
    @(posedge rd_clk) disable iff (!r_rst_n)
    $rose(r_rst_n) |-> rbin_r == `EFC_PTR_RST && empty_r && nearly_drained_flag_r)
    else $error("read side not emptied by reset");

  a_upper_bits_zero: assert property (
    @(posedge rd_clk) disable iff (!r_rst_n)
    r_rst_n |-> (rdata_r >> rwidth) == `EFC_DATA_RST)
    else $error("read word has bits set above the port width");

  a_rfill_within_depth: assert property (
    @(posedge rd_clk) disable iff (!r_rst_n)
    r_rst_n |-> rfill <= rdepth)
    else $error("read side fill level outside the fifo depth");

endmodule

// ==== dv/efc_read_model.sv ====
// read side user logic model with its own unrelated clock
`timescale 1ns/1ps
`include "efc_map.svh"

module efc_read_model (
  output logic                        rd_clk,
  output logic                        rd_en,
  input  wire logic                   empty,
  input  wire logic [`EFC_DATA_W-1:0] read_word_out
);
  // odd offset keeps this clock's edges off the write clock's edges
  initial
  begin
    rd_clk = 1'b0;
    rd_en  = 1'b0;
    #37.3;
    forever
      #68.5 rd_clk = ~rd_clk;
  end

  // one request per call; a word taken while empty showed is not trusted
  task automatic pop(output logic [`EFC_DATA_W-1:0] word,
                     output logic valid);
    logic was_empty;
    @(negedge rd_clk);
    was_empty = empty;
    rd_en     = 1'b1;
    @(posedge rd_clk);
    @(negedge rd_clk);
    rd_en = 1'b0;
    word  = read_word_out;
    valid = ~was_empty;
  endtask
endmodule

// ==== dv/efc_fifo_ctrl_test.sv ====
// self-checking bench of the dual clock fifo controller
`timescale 1ns/1ps
`include "efc_map.svh"

module efc_fifo_ctrl_test;
  logic                   ref_clk;
  logic                   rd_clk;
  logic                   resetn;
  efc_pkg::efc_cfg_s      cfg;
  logic [`EFC_DATA_W-1:0] write_word_in;
  logic                   wr_en;
  logic                   rd_en;
  logic [`EFC_DATA_W-1:0] read_word_out;
  logic                   full;
  logic                   nearly_filled_flag;
  logic                   empty;
  logic                   nearly_drained_flag;
  int                     n_fail;
  int                     cmp_count;
  int                     wid [6] = '{1, 2, 4, 9, 18, 36};

  efc_fifo_ctrl dut (
    .wr_clk              (ref_clk),
    .rd_clk              (rd_clk),
    .resetn              (resetn),
    .cfg                 (cfg),
    .write_word_in       (write_word_in),
    .wr_en               (wr_en),
    .rd_en               (rd_en),
    .read_word_out       (read_word_out),
    .full                (full),
    .nearly_filled_flag  (nearly_filled_flag),
    .empty               (empty),
    .nearly_drained_flag (nearly_drained_flag)
  );

  efc_read_model u_reader (
    .rd_clk        (rd_clk),
    .rd_en         (rd_en),
    .empty         (empty),
    .read_word_out (read_word_out)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever
      #50 ref_clk = ~ref_clk;
  end

  task automatic check_bit(string what, logic exp, logic got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_word(string what, logic [35:0] exp, logic [35:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [35:0] pattern(int i);
    pattern = {4'hC, (32'(i) * 32'h0001_0003) ^ 32'h5A5A_5A5A};
  endfunction

  // reset is held well past both synchronisers, not just two cycles
  task automatic restart(int as, int depth);
    @(negedge ref_clk);
    resetn                 = 1'b0;
    cfg.aspect             = efc_pkg::efc_aspect_e'(as[2:0]);
    cfg.nearly_full_level  = efc_pkg::efc_ptr_t'(depth - 2);
    cfg.nearly_empty_level = 13'h0003;
    repeat (10) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    check_bit("empty", 1'b1, empty);
    check_bit("full", 1'b0, full);
    check_bit("nearly full", 1'b0, nearly_filled_flag);
    check_bit("nearly drained", 1'b1, nearly_drained_flag);
    check_word("read word", 36'h0_0000_0000, read_word_out);
  endtask

  // called at a falling edge; leaves wr_en high for back to back writes
  task automatic push(logic [35:0] data);
    write_word_in = data;
    wr_en         = 1'b1;
    @(negedge ref_clk);
  endtask

  initial
  begin
    int          depth;
    logic [35:0] mask;
    logic [35:0] w;
    logic        v;
    n_fail        = 0;
    cmp_count     = 0;
    resetn        = 1'b0;
    wr_en         = 1'b0;
    write_word_in = 36'h0_0000_0000;
    cfg           = '0;
    for (int a = 0; a < 6; a++)
    begin
      depth = 4096 >> a;
      mask  = (36'h0_0000_0001 << wid[a]) - 36'h0_0000_0001;
      restart(a, depth);
      for (int i = 0; i < depth; i++)
      begin
        push(pattern(i));
        check_bit("full", (i + 1 == depth), full);
        check_bit("nearly full", (i + 1 >= depth - 2),
                  nearly_filled_flag);
      end
      push(36'h3_3333_3333);
      wr_en = 1'b0;
      check_bit("full", 1'b1, full);
      repeat (8) @(negedge ref_clk);
      check_bit("empty", 1'b0, empty);
      check_bit("nearly drained", 1'b0, nearly_drained_flag);
      for (int i = 0; i < depth; i++)
      begin
        u_reader.pop(w, v);
        check_bit("valid", 1'b1, v);
        check_word("read word", pattern(i) & mask, w);
        check_bit("nearly drained", (depth - 1 - i <= 3),
                  nearly_drained_flag);
      end
      check_bit("empty", 1'b1, empty);
      // the word offered while full must not appear here
      u_reader.pop(w, v);
      check_bit("valid", 1'b0, v);
      check_word("read word", pattern(depth - 1) & mask,
                 read_word_out);
      repeat (8) @(negedge ref_clk);
      check_bit("full", 1'b0, full);
    end
    finish_test();
  end

  initial
  begin
    #5_000_000;
    n_fail++;
    $display("BAD watchdog expected done seen hang");
    finish_test();
  end
endmodule
